// >>> vbitr_pkg.sv
`default_nettype none
// ----------------------------------------------------------------------------
// register map, field layout and timing constants
// ----------------------------------------------------------------------------
package vbitr_pkg;
   localparam logic [7:0] ADDR_CAPTION_TELETEXT_CONTROL = 8'h6F;
   localparam logic [7:0] ADDR_REF2_PULSE_START_LOW     = 8'h70;
   localparam logic [7:0] ADDR_REF2_PULSE_END_LOW       = 8'h71;
   localparam logic [7:0] ADDR_REF2_PULSE_HIGH_BITS     = 8'h72;
   localparam logic [7:0] ADDR_TELETEXT_REQUEST_START   = 8'h73;
   localparam logic [7:0] ADDR_TELETEXT_DATA_DELAY      = 8'h74;
   localparam logic [7:0] ADDR_SYNC_ADVANCE_SHIFT       = 8'h75;
   localparam logic [7:0] ADDR_TELETEXT_ODD_FIRST_LINE  = 8'h76;
   localparam logic [7:0] ADDR_HIGH_LINE_BITS           = 8'h7C;
   // field positions
   localparam int CAPTION_EN_HI    = 7;
   localparam int CAPTION_EN_LO    = 6;
   localparam int TELETEXT_EN_BIT  = 5;
   localparam int START_HI_LSB     = 0;
   localparam int END_HI_LSB       = 4;
   localparam int ADVANCE_LSB      = 3;
   localparam int ODD_LINE_MSB_BIT = 5;
   localparam logic [7:0] HIGH_BITS_WMASK = 8'h77;
   // line offsets
   localparam logic [8:0] LINE_OFS_M     = 9'h004;
   localparam logic [8:0] LINE_OFS_OTHER = 9'h001;
   // reset values, reference alignment code, line limits, minimum data delay and advance depth
   localparam logic [7:0] RST_CONTROL    = 8'h00;
   localparam logic [7:0] RST_REQ_START  = 8'h42;
   localparam logic [7:0] RST_DATA_DELAY = 8'h02;
   localparam logic [7:0] RST_SHIFT      = 8'h03;
   localparam logic [7:0] RST_ODD_LINE   = 8'h05;
   localparam logic [10:0] REF2_ALIGN_CODE = 11'h049;
   localparam logic [10:0] LINE_LAST_60  = 11'd1715;
   localparam logic [10:0] LINE_LAST_50  = 11'd1727;
   localparam logic [7:0] DELAY_MIN     = 8'h02;
   localparam int         ADVANCE_DEPTH = 32;
endpackage : vbitr_pkg
`default_nettype wire

// >>> vbitr_sync_adv.sv
`default_nettype none
// ----------------------------------------------------------------------------
// composite sync advance: composite sync delayed by depth+1-advance cycles, rgb sync by depth+1
// ----------------------------------------------------------------------------
module vbitr_sync_adv #(
   parameter int DEPTH = 32
) (
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic                     sync_in,
   input  wire logic [$clog2(DEPTH)-1:0] advance,
   output logic                          csync_out,
   output logic                          rgb_sync_out
);
   localparam int TAP_W = $clog2(DEPTH);
   logic [DEPTH-1:0] line;
   logic [TAP_W-1:0] rgb_tap;

   // taps: composite leaves advance cycles ahead of rgb
   assign rgb_tap = TAP_W'(DEPTH - 1);

   // shift line of past sync samples
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         line <= '0;
      end else begin
         line <= {line[DEPTH-2:0], sync_in};
      end
   end

   // output taps registered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         csync_out    <= 1'b0;
         rgb_sync_out <= 1'b0;
      end else begin
         csync_out    <= line[rgb_tap - advance];
         rgb_sync_out <= line[rgb_tap];
      end
   end
endmodule : vbitr_sync_adv
`default_nettype wire

// >>> vbitr_regs.sv
// Functional notes
// R1 - caption enable bits 7:6: 00 off, 01 odd, 10 even, 11 both fields.
// R2 - teletext enable bit 5 gates insertion; cleared at reset.
// R3 - caption line equals field plus 4 for M-systems, plus 1 otherwise.
// R4 - pulse start is 11 bits: low byte 70h, upper three from 72h bits 2:0.
// R5 - pulse end is 11 bits: low byte 71h, upper three from 72h bits 6:4.
// R6 - host keeps start and end at or below 1715 or 1727 per field rate.
// R7 - start code 49h puts pulse leading edge on the composite sync slope.
// R8 - end code 49h puts pulse trailing edge on the composite sync slope.
// R9 - host writes zero to reserved bits 7 and 3 of 72h.
// R10 - eight-bit field sets horizontal position where teletext request rises.
// R11 - data is sampled the programmed cycles after request rises, at least 2.
// R12 - bits 7:3 advance composite sync against rgb by 0 to 31 clocks.
// R13 - three-bit field shifts first-reference vsync against hsync in master mode.
// R14 - nine-bit first odd teletext line; high bit at 7Ch; plus 4 or plus 1.
// R15 - second reference output active from start count until end count.
`default_nettype none
module vbitr_regs
   import vbitr_pkg::*;
#(
   parameter int ADVANCE_DEPTH_P = vbitr_pkg::ADVANCE_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   input  wire logic        field_rate_select,
   input  wire logic        m_system,
   input  wire logic        odd_field,
   input  wire logic [10:0] hcount,
   input  wire logic [8:0]  line_count,
   input  wire logic        hsync_in,
   input  wire logic        vsync_in,
   input  wire logic        sync_in,
   input  wire logic        teletext_data_in,
   output logic             second_reference_output,
   output logic             first_reference_output,
   output logic             teletext_request_out,
   output logic             teletext_bit_valid,
   output logic             teletext_bit,
   output logic             caption_line_active,
   output logic             csync_out,
   output logic             rgb_sync_out,
   output logic             ref_code_error
);
   import vbitr_pkg::*;

   // ------------------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------------------
   logic [7:0] caption_teletext_control;
   logic [7:0] ref2_pulse_start_low;
   logic [7:0] ref2_pulse_end_low;
   logic [7:0] ref2_pulse_high_bits;
   logic [7:0] teletext_request_start;
   logic [7:0] teletext_data_delay;
   logic [7:0] sync_advance_shift;
   logic [7:0] teletext_odd_first_line;
   logic [7:0] high_line_bits;

   // decode of write strobes
   wire wr_ctl  = reg_wr && (reg_addr == ADDR_CAPTION_TELETEXT_CONTROL);
   wire wr_sl   = reg_wr && (reg_addr == ADDR_REF2_PULSE_START_LOW);
   wire wr_el   = reg_wr && (reg_addr == ADDR_REF2_PULSE_END_LOW);
   wire wr_hb   = reg_wr && (reg_addr == ADDR_REF2_PULSE_HIGH_BITS);
   wire wr_rs   = reg_wr && (reg_addr == ADDR_TELETEXT_REQUEST_START);
   wire wr_dd   = reg_wr && (reg_addr == ADDR_TELETEXT_DATA_DELAY);
   wire wr_sa   = reg_wr && (reg_addr == ADDR_SYNC_ADVANCE_SHIFT);
   wire wr_ol   = reg_wr && (reg_addr == ADDR_TELETEXT_ODD_FIRST_LINE);
   wire wr_7c   = reg_wr && (reg_addr == ADDR_HIGH_LINE_BITS);

   // register writes
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         caption_teletext_control <= RST_CONTROL;       // R1 R2
         ref2_pulse_start_low     <= 8'h00;
         ref2_pulse_end_low       <= 8'h00;
         ref2_pulse_high_bits     <= 8'h00;
         teletext_request_start   <= RST_REQ_START;
         teletext_data_delay      <= RST_DATA_DELAY;
         sync_advance_shift       <= RST_SHIFT;
         teletext_odd_first_line  <= RST_ODD_LINE;
         high_line_bits           <= 8'h00;
      end else begin
         if (wr_ctl) caption_teletext_control <= reg_wdata;
         if (wr_sl) ref2_pulse_start_low <= reg_wdata;
         if (wr_el) ref2_pulse_end_low <= reg_wdata;
         if (wr_hb) ref2_pulse_high_bits <= reg_wdata & HIGH_BITS_WMASK;  // R9
         if (wr_rs) teletext_request_start <= reg_wdata;
         if (wr_dd) teletext_data_delay <= reg_wdata;
         if (wr_sa) sync_advance_shift <= reg_wdata;
         if (wr_ol) teletext_odd_first_line <= reg_wdata;
         if (wr_7c) high_line_bits <= reg_wdata;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      unique case (reg_addr)
         ADDR_CAPTION_TELETEXT_CONTROL: reg_rdata = caption_teletext_control;
         ADDR_REF2_PULSE_START_LOW:     reg_rdata = ref2_pulse_start_low;
         ADDR_REF2_PULSE_END_LOW:       reg_rdata = ref2_pulse_end_low;
         ADDR_REF2_PULSE_HIGH_BITS:     reg_rdata = ref2_pulse_high_bits;
         ADDR_TELETEXT_REQUEST_START:   reg_rdata = teletext_request_start;
         ADDR_TELETEXT_DATA_DELAY:      reg_rdata = teletext_data_delay;
         ADDR_SYNC_ADVANCE_SHIFT:       reg_rdata = sync_advance_shift;
         ADDR_TELETEXT_ODD_FIRST_LINE:  reg_rdata = teletext_odd_first_line;
         ADDR_HIGH_LINE_BITS:           reg_rdata = high_line_bits;
         default:                       reg_rdata = 8'h00;
      endcase
   end

   // ------------------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------------------
   function automatic logic [8:0] line_of(input logic [8:0] code, input logic msys);
      line_of = code + (msys ? LINE_OFS_M : LINE_OFS_OTHER);
   endfunction : line_of

   wire [1:0]  caption_field_enable   = caption_teletext_control[CAPTION_EN_HI:CAPTION_EN_LO];
   wire        teletext_insert_enable = caption_teletext_control[TELETEXT_EN_BIT];
   wire [4:0]  caption_line_select    = caption_teletext_control[4:0];
   wire [10:0] ref2_pulse_start = {ref2_pulse_high_bits[START_HI_LSB +: 3],
                                   ref2_pulse_start_low};                       // R4
   wire [10:0] ref2_pulse_end   = {ref2_pulse_high_bits[END_HI_LSB +: 3],
                                   ref2_pulse_end_low};                         // R5
   wire [4:0]  sync_advance     = sync_advance_shift[ADVANCE_LSB +: 5];
   wire [2:0]  vertical_shift   = sync_advance_shift[2:0];
   wire [8:0]  odd_first_code   = {high_line_bits[ODD_LINE_MSB_BIT],
                                   teletext_odd_first_line};                    // R14
   wire [8:0]  caption_line     = line_of({4'h0, caption_line_select}, m_system);  // R3
   wire [8:0]  odd_first_line   = line_of(odd_first_code, m_system);            // R14
   wire [10:0] line_last        = field_rate_select ? LINE_LAST_60 : LINE_LAST_50;

   // caption line qualified by the field enable
   wire field_ok = odd_field ? caption_field_enable[0] : caption_field_enable[1];  // R1
   assign caption_line_active = field_ok && (line_count == caption_line);           // R1 R3

   // out-of-range codes flagged for the host
   assign ref_code_error = (ref2_pulse_start > line_last) || (ref2_pulse_end > line_last);

   // ------------------------------------------------------------------------
   // second reference pulse; hcount zero is aligned so 49h is the sync slope
   // ------------------------------------------------------------------------
   wire hit_start = (hcount == ref2_pulse_start);   // R7
   wire hit_end   = (hcount == ref2_pulse_end);     // R8
   logic ref2_q;
   logic next_ref2;
   assign next_ref2 = hit_start ? 1'b1 : (hit_end ? 1'b0 : ref2_q);  // R15

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) ref2_q <= 1'b0;
      else ref2_q <= next_ref2;
   end

   // master mode: vsync shifted by vertical_shift lines against hsync
   logic [7:0] vs_line;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) vs_line <= 8'h00;
      else if (hsync_in) vs_line <= {vs_line[6:0], vsync_in};   // R13
   end

   // outputs registered
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         second_reference_output <= 1'b0;
         first_reference_output  <= 1'b0;
      end else begin
         second_reference_output <= next_ref2;                  // R15
         first_reference_output  <= vs_line[vertical_shift];    // R13
      end
   end

   // ------------------------------------------------------------------------
   // teletext request and data capture
   // ------------------------------------------------------------------------
   typedef enum logic [2:0] {
      VBITR_IDLE = 3'b001,
      VBITR_WAIT = 3'b010,
      VBITR_TAKE = 3'b100
   } vbitr_state_e;
   vbitr_state_e state;
   vbitr_state_e next_state;
   logic [7:0] wait_cnt;
   wire [7:0] eff_delay = (teletext_data_delay < DELAY_MIN) ? DELAY_MIN
                                                            : teletext_data_delay;  // R11
   wire tt_line  = teletext_insert_enable && odd_field && (line_count >= odd_first_line);  // R2 R14
   wire req_hit  = tt_line && (hcount == {3'b000, teletext_request_start});           // R10

   always_comb begin
      next_state = state;
      unique case (state)
         VBITR_IDLE: if (req_hit) next_state = VBITR_WAIT;
         VBITR_WAIT: if (wait_cnt == eff_delay - 8'h02) next_state = VBITR_TAKE;  // R11
         VBITR_TAKE: next_state = VBITR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state    <= VBITR_IDLE;
         wait_cnt <= 8'h00;
      end else begin
         state    <= next_state;
         wait_cnt <= (state == VBITR_WAIT) ? wait_cnt + 8'h01 : 8'h00;
      end
   end

   // request high while waiting; data bit taken at delay count after rise
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         teletext_request_out <= 1'b0;
         teletext_bit_valid   <= 1'b0;
         teletext_bit         <= 1'b0;
      end else begin
         teletext_request_out <= (next_state == VBITR_WAIT);    // R10
         teletext_bit_valid   <= (state == VBITR_TAKE);         // R11
         if (state == VBITR_TAKE) teletext_bit <= teletext_data_in;
      end
   end

   vbitr_sync_adv #(.DEPTH(ADVANCE_DEPTH_P)) u_adv (
      .clk          (clk),
      .nrst         (nrst),
      .sync_in      (sync_in),
      .advance      (sync_advance),           // R12
      .csync_out    (csync_out),
      .rgb_sync_out (rgb_sync_out)
   );

   // ------------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------------
   property p_ref2_rise;
      @(posedge clk) disable iff (!nrst) hit_start |=> second_reference_output;
   endproperty
   a_ref2_rise: assert property (p_ref2_rise) else $error("pulse not raised at start"); // R7
   property p_ref2_fall;
      @(posedge clk) disable iff (!nrst) (hit_end && !hit_start) |=> !second_reference_output;
   endproperty
   a_ref2_fall: assert property (p_ref2_fall) else $error("pulse not dropped at end"); // R8
   property p_ref2_hold;
      @(posedge clk) disable iff (!nrst)
         (!hit_start && !hit_end) |=> $stable(second_reference_output);
   endproperty
   a_ref2_hold: assert property (p_ref2_hold) else $error("pulse moved"); // R15
   property p_tt_off;
      @(posedge clk) disable iff (!nrst)
         (!teletext_insert_enable && state == VBITR_IDLE) |=> !teletext_request_out;
   endproperty
   a_tt_off: assert property (p_tt_off) else $error("request while disabled"); // R2
   property p_tt_delay;
      @(posedge clk) disable iff (!nrst)
         $rose(teletext_request_out) && eff_delay == DELAY_MIN && $stable(eff_delay)
         |-> ##2 teletext_bit_valid;
   endproperty
   a_tt_delay: assert property (p_tt_delay) else $error("data not taken at delay"); // R11
   property p_tt_req_len;
      @(posedge clk) disable iff (!nrst) teletext_bit_valid |-> !teletext_request_out;
   endproperty
   a_tt_req_len: assert property (p_tt_req_len) else $error("request overlaps sample"); // R10
   property p_caption_off;
      @(posedge clk) disable iff (!nrst) caption_field_enable == 2'b00 |-> !caption_line_active;
   endproperty
   a_caption_off: assert property (p_caption_off) else $error("caption while off"); // R1
   property p_caption_line;
      @(posedge clk) disable iff (!nrst)
         caption_line_active |-> line_count == 9'(caption_line_select) + (m_system ? 9'd4 : 9'd1);
   endproperty
   a_caption_line: assert property (p_caption_line) else $error("wrong caption line"); // R3
   property p_reserved;
      @(posedge clk) disable iff (!nrst) ref2_pulse_high_bits[7] == 1'b0 && !ref2_pulse_high_bits[3];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set"); // R9
   c_ref2: cover property (@(posedge clk) disable iff (!nrst) $rose(second_reference_output));
   c_tt:   cover property (@(posedge clk) disable iff (!nrst) teletext_bit_valid);
   c_cap:  cover property (@(posedge clk) disable iff (!nrst) caption_line_active);
endmodule : vbitr_regs
`default_nettype wire

// >>> vbitr_ttx_source.sv
`default_nettype none
// ----------------------------------------------------------------------------
// teletext source: one valid bit exactly at the programmed delay
// ----------------------------------------------------------------------------
module vbitr_ttx_source (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       request,
   input  wire logic [7:0] delay,
   input  wire logic       bit_value,
   output logic            data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       req_q;
   logic [8:0] cnt;
   logic [8:0] next_cnt;
   // cycles since the request rose, held at the top once long past
   assign next_cnt = (request && !req_q) ? 9'h001 :
                     (cnt != 9'h000 && cnt != 9'h1FF) ? cnt + 9'h001 : cnt;
   // valid only in the cycle before the delay edge, toggling junk elsewhere
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         req_q <= 1'b0;
         cnt   <= 9'h000;
         data  <= 1'b0;
      end else begin
         req_q <= request;
         cnt   <= next_cnt;
         data  <= (next_cnt == {1'b0, delay} - 9'h001) ? bit_value : ~data;
      end
   end
endmodule : vbitr_ttx_source
`default_nettype wire

// >>> vbitr_regs_test.sv
`default_nettype none
module vbitr_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import vbitr_pkg::*;
   logic        clk, nrst, reg_wr, frs, m_sys, odd, sync_in, ttx_data, tt_bit;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, ttx_delay, tt_start;
   logic [10:0] hcount = 11'd0;
   logic [10:0] ref_start, ref_end;
   logic [8:0]  line_count;
   logic        ref_out, ref_err, req_out, bit_valid, ttx_bit, cap_act, csync, rgb_sync;
   logic        exp_ref = 1'b0;
   logic        req_q = 1'b0;
   logic        chk_ref = 1'b0;
   logic        hs_in = 1'b0;
   logic        vs_in = 1'b0;
   logic        ref1;
   int          failures, n_tests, cycles, rises, valids;
   // ----------------------------------------------------------------------------
   // design and teletext source
   // ----------------------------------------------------------------------------
   vbitr_regs i_dut (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .field_rate_select(frs),
      .m_system(m_sys), .odd_field(odd), .hcount(hcount), .line_count(line_count),
      .hsync_in(hs_in), .vsync_in(vs_in), .sync_in(sync_in), .teletext_data_in(ttx_data),
      .second_reference_output(ref_out), .first_reference_output(ref1),
      .teletext_request_out(req_out), .teletext_bit_valid(bit_valid),
      .teletext_bit(ttx_bit), .caption_line_active(cap_act), .csync_out(csync),
      .rgb_sync_out(rgb_sync), .ref_code_error(ref_err));
   vbitr_ttx_source i_src (.clk(clk), .nrst(nrst), .request(req_out), .delay(ttx_delay),
      .bit_value(tt_bit), .data(ttx_data));
   // clock and free-running pixel counter over a 1728-clock line
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) hcount <= (hcount == 11'd1727) ? 11'd0 : hcount + 11'd1;
   // ----------------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : check
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      @(negedge clk);
      check("register read", 16'(e), 16'(reg_rdata));
   endtask : rd
   task automatic next_line();
      do @(posedge clk); while (hcount !== 11'd0);
   endtask : next_line
   // watchdog, reference pulse model and teletext monitor
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         failures++;
         finish_test();
      end
   end
   always @(posedge clk) begin
      if (chk_ref) check("second reference", 16'(exp_ref), 16'(ref_out));
      exp_ref <= (hcount == ref_start) ? 1'b1 : (hcount == ref_end) ? 1'b0 : exp_ref;
      if (req_out === 1'b1 && !req_q) begin
         rises++;
         check("request start", 16'(tt_start) + 16'h0001, 16'(hcount));
      end
      req_q <= req_out;
      if (bit_valid === 1'b1) begin
         valids++;
         check("teletext bit", 16'(tt_bit), 16'(ttx_bit));
      end
   end
   // ----------------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------------
   localparam logic [7:0]  RA [10] = '{8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75,
                                       8'h76, 8'h7C, 8'h77};
   localparam logic [7:0]  RV [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h42, 8'h02, 8'h03,
                                       8'h05, 8'h00, 8'h00};
   localparam logic [10:0] RS [2]  = '{11'h049, 11'h3C2};
   localparam logic [10:0] RE [2]  = '{11'h105, 11'h049};
   localparam logic [10:0] EC [4]  = '{11'd1715, 11'd1716, 11'd1727, 11'd1728};
   localparam logic [7:0]  TS [6]  = '{8'h54, 8'h42, 8'h60, 8'h54, 8'h54, 8'h54};
   localparam logic [7:0]  TD [6]  = '{8'h02, 8'h05, 8'h03, 8'h02, 8'h02, 8'h02};
   localparam logic [8:0]  TL [6]  = '{9'd6, 9'd9, 9'd6, 9'd5, 9'd9, 9'd8};
   localparam logic [5:0]  TEN = 6'b111011;
   localparam logic [5:0]  TM  = 6'b110000;
   localparam logic [5:0]  TX  = 6'b010011;
   localparam logic [4:0]  ADV [3] = '{5'd0, 5'd5, 5'd31};
   localparam logic [2:0]  SHF [2] = '{3'd3, 3'd7};
   initial begin
      int cs;
      int rg;
      nrst = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; frs = 1'b0;
      m_sys = 1'b0; odd = 1'b0; sync_in = 1'b0; line_count = 9'd0; tt_bit = 1'b0;
      ttx_delay = 8'h02; tt_start = 8'h42; ref_start = 11'd0; ref_end = 11'd0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      for (int i = 0; i < 10; i++) rd(RA[i], RV[i]);
      wr(ADDR_REF2_PULSE_HIGH_BITS, 8'hFF);
      rd(ADDR_REF2_PULSE_HIGH_BITS, 8'h77);
      wr(8'h77, 8'hFF);
      rd(8'h77, 8'h00);
      wr(ADDR_CAPTION_TELETEXT_CONTROL, 8'hA5);
      rd(ADDR_CAPTION_TELETEXT_CONTROL, 8'hA5);
      $display("test register access done");
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_REF2_PULSE_START_LOW, RS[i][7:0]);
         wr(ADDR_REF2_PULSE_END_LOW, RE[i][7:0]);
         wr(ADDR_REF2_PULSE_HIGH_BITS, {1'b0, RE[i][10:8], 1'b0, RS[i][10:8]});
         ref_start = RS[i];
         ref_end = RE[i];
         next_line();
         next_line();
         chk_ref <= 1'b1;
         next_line();
         chk_ref <= 1'b0;
      end
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_REF2_PULSE_START_LOW, EC[i][7:0]);
         wr(ADDR_REF2_PULSE_HIGH_BITS, {5'h00, EC[i][10:8]});
         frs <= (i < 2);
         @(negedge clk);
         check("code limit", 16'(i[0]), 16'(ref_err));
      end
      $display("test reference pulse done");
      for (int k = 0; k < 16; k++) begin
         wr(ADDR_CAPTION_TELETEXT_CONTROL, {k[3:2], 1'b0, 5'h0A});
         odd <= k[1];
         m_sys <= k[0];
         line_count <= 9'h00A + (k[0] ? LINE_OFS_M : LINE_OFS_OTHER);
         @(negedge clk);
         check("caption line", 16'(k[1] ? k[2] : k[3]), 16'(cap_act));
         @(posedge clk);
         line_count <= line_count + 9'h001;
         @(negedge clk);
         check("caption other line", 16'h0000, 16'(cap_act));
      end
      $display("test caption done");
      for (int i = 0; i < 6; i++) begin
         tt_start = TS[i];
         ttx_delay = TD[i];
         tt_bit = i[0];
         wr(ADDR_TELETEXT_REQUEST_START, TS[i]);
         wr(ADDR_TELETEXT_DATA_DELAY, TD[i]);
         wr(ADDR_CAPTION_TELETEXT_CONTROL, {2'b00, TEN[i], 5'h00});
         odd <= 1'b1;
         m_sys <= TM[i];
         line_count <= TL[i];
         next_line();
         rises = 0;
         valids = 0;
         next_line();
         check("request count", 16'(TX[i]), 16'(rises));
         check("data count", 16'(TX[i]), 16'(valids));
      end
      $display("test teletext done");
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_SYNC_ADVANCE_SHIFT, {ADV[i], 3'h3});
         sync_in <= 1'b1;
         cs = -1;
         rg = -1;
         for (int t = 0; t < 80; t++) begin
            @(posedge clk);
            if (csync === 1'b1 && cs < 0) cs = t;
            if (rgb_sync === 1'b1 && rg < 0) rg = t;
         end
         check("sync advance", 16'(ADV[i]), 16'(rg - cs));
         sync_in <= 1'b0;
         repeat (80) @(posedge clk);
      end
      $display("test sync advance done");
      // one vsync mark shifted along by hsync pulses
      for (int i = 0; i < 2; i++) begin
         wr(ADDR_SYNC_ADVANCE_SHIFT, {5'h00, SHF[i]});
         for (int h = 0; h < 10; h++) begin
            @(posedge clk);
            hs_in <= 1'b1;
            vs_in <= (h == 0);
            @(posedge clk);
            hs_in <= 1'b0;
            @(posedge clk);
            @(negedge clk);
            check("first reference", 16'(h == SHF[i]), 16'(ref1));
         end
      end
      $display("test vertical shift done");
      finish_test();
   end
endmodule : vbitr_regs_test
`default_nettype wire
